//--- verilog/fcsh_map.vh
// constants of the fieldbus control and status handshake block
// assumes inclusion by the handshake logic and its helpers
`ifndef FCSH_MAP_VH
`define FCSH_MAP_VH

// exchange byte offsets
`define FCSH_OFS_STATE_FLAGS    1'h0
`define FCSH_OFS_CUR_JOB        1'h1
`define FCSH_OFS_REQ_FLAGS      1'h0
`define FCSH_OFS_REQ_JOB        1'h1

// sensor_state_flags bits
`define FCSH_ST_ONLINE          0
`define FCSH_ST_RUN_ACK         1
`define FCSH_ST_LOAD_ACK        3
`define FCSH_ST_LOAD_OK         4
`define FCSH_ST_READY           5
`define FCSH_ST_CAP_ACK         6

// host_request_flags bits
`define FCSH_RQ_RUN             0
`define FCSH_RQ_LOAD            1
`define FCSH_RQ_STARTUP         2
`define FCSH_RQ_CAPTURE         3

// compat_device_control bits
`define FCSH_CC_OFFLINE         0
`define FCSH_CC_JOB_CHANGE      1
`define FCSH_CC_LIGHTS_OFF      3
`define FCSH_CC_NUM_LO          8
`define FCSH_CC_NUM_HI          15

// compat_device_state bits
`define FCSH_CS_ONLINE          0
`define FCSH_CS_FAULT           4
`define FCSH_CS_LOAD_DONE       5
`define FCSH_CS_LOAD_FAIL       6

// compat_capture_control bits
`define FCSH_CA_TRIGGER         0

// reset values
`define FCSH_RST_BYTE           8'h00
`define FCSH_RST_WORD           16'h0000

// exchange timing
`define FCSH_CYCLE_MS           8
`define FCSH_CLK_MHZ            250
`define FCSH_CYCLE_CLKS         (`FCSH_CYCLE_MS * 1000 * `FCSH_CLK_MHZ)

`endif

//--- verilog/fcsh_tick.v
// exchange cycle timer: one pulse per update period
// assumes the system clock and reset of the handshake block
`timescale 1ns/1ps
`include "fcsh_map.vh"

module fcsh_tick #(
	parameter [20:0] CYCLE_CLKS = `FCSH_CYCLE_CLKS
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// cycle pulse
	output reg         tick
);

reg [20:0] count;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		count <= 21'h000000;
		tick  <= 1'b0;
	end else if (count == CYCLE_CLKS - 21'h000001) begin
		count <= 21'h000000;
		tick  <= 1'b1;
	end else begin
		count <= count + 21'h000001;
		tick  <= 1'b0;
	end
end

endmodule

//--- verilog/fcsh_edge.v
// once-per-cycle sampler with edge detection against the last sample
// assumes sampled inputs are on the same clock as the block
`timescale 1ns/1ps

module fcsh_edge #(
	parameter W = 13
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst_n,
	// sample strobe and data
	input  wire         tick,
	input  wire [W-1:0] din,
	// results
	output reg          stb,
	output reg  [W-1:0] smp,
	output wire [W-1:0] rise,
	output wire [W-1:0] fall
);

reg [W-1:0] prev;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		smp  <= {W{1'b0}};
		prev <= {W{1'b0}};
		stb  <= 1'b0;
	end else begin
		stb <= tick;
		if (tick) begin
			prev <= smp;
			smp  <= din;
		end
	end
end

assign rise = {W{stb}} & smp & ~prev;
assign fall = {W{stb}} & ~smp & prev;

endmodule

//--- verilog/fcsh_handshake.v
// fieldbus control and status handshake, device side
// assumes control bytes come from fieldbus logic on MCLK, loader and
// inspection engine also on MCLK
// exchange period set by CYCLE_CLKS, default 8 ms
`timescale 1ns/1ps
`include "fcsh_map.vh"

module fcsh_handshake #(
	parameter [20:0] CYCLE_CLKS = `FCSH_CYCLE_CLKS
) (
	// clock and reset
	input  wire        MCLK,
	input  wire        RST_N,
	// standard control bytes
	input  wire [7:0]  HOST_REQUEST_FLAGS,
	input  wire [7:0]  REQUESTED_JOB_NUMBER,
	// compatibility control modules
	input  wire        COMPAT_MODE,
	input  wire [15:0] COMPAT_DEVICE_CONTROL,
	input  wire [7:0]  COMPAT_CAPTURE_CONTROL,
	// standard status bytes
	output reg  [7:0]  SENSOR_STATE_FLAGS,
	output reg  [7:0]  CURRENT_JOB_NUMBER,
	// compatibility status module
	output reg  [15:0] COMPAT_DEVICE_STATE,
	// program loader
	output reg         LOAD_START,
	output reg  [7:0]  LOAD_NUMBER,
	output reg         LOAD_STARTUP,
	input  wire        LOAD_DONE,
	input  wire        LOAD_OK,
	// inspection engine
	output reg         RUN_ENABLE,
	output reg         CAPTURE_START,
	input  wire        INSPECT_BUSY,
	input  wire        TRIG_SRC_FIELDBUS,
	// illumination
	output reg         LIGHTS_OFF
);

localparam [1:0] S_OFF  = 2'b00;
localparam [1:0] S_ON   = 2'b01;
localparam [1:0] S_STOP = 2'b10;
localparam [1:0] S_LOAD = 2'b11;

// sample bundle positions
localparam I_RUN   = 0;
localparam I_LOAD  = 1;
localparam I_BOOT  = 2;
localparam I_TRIG  = 3;
localparam I_LIGHT = 4;
localparam I_NUM   = 5;

////////////////////////////////////////////////////////////////////////////
// state decode

// online covers running and stopping
function is_online;
	input [1:0] s;
	begin
		is_online = (s == S_ON) || (s == S_STOP);
	end
endfunction

// running excludes stopping
function is_running;
	input [1:0] s;
	begin
		is_running = (s == S_ON);
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// exchange cycle and sampling

wire        tick;
wire        stb;
wire [12:0] smp;
wire [12:0] rise;
wire [12:0] fall;
reg  [12:0] bundle;

fcsh_tick #(
	.CYCLE_CLKS (CYCLE_CLKS)
) u_tick (
	.clk   (MCLK),
	.rst_n (RST_N),
	.tick  (tick)
);

// unsupported control bits never enter the bundle
always @* begin
	bundle = 13'h0000;
	if (COMPAT_MODE) begin
		bundle[I_RUN]   = ~COMPAT_DEVICE_CONTROL[`FCSH_CC_OFFLINE];
		bundle[I_LOAD]  = COMPAT_DEVICE_CONTROL[`FCSH_CC_JOB_CHANGE];
		bundle[I_BOOT]  = 1'b0;
		bundle[I_TRIG]  = COMPAT_CAPTURE_CONTROL[`FCSH_CA_TRIGGER];
		bundle[I_LIGHT] = COMPAT_DEVICE_CONTROL[`FCSH_CC_LIGHTS_OFF];
		bundle[12:I_NUM] =
			COMPAT_DEVICE_CONTROL[`FCSH_CC_NUM_HI:`FCSH_CC_NUM_LO];
	end else begin
		bundle[I_RUN]   = HOST_REQUEST_FLAGS[`FCSH_RQ_RUN];
		bundle[I_LOAD]  = HOST_REQUEST_FLAGS[`FCSH_RQ_LOAD];
		bundle[I_BOOT]  = HOST_REQUEST_FLAGS[`FCSH_RQ_STARTUP];
		bundle[I_TRIG]  = HOST_REQUEST_FLAGS[`FCSH_RQ_CAPTURE];
		bundle[I_LIGHT] = 1'b0;
		bundle[12:I_NUM] = REQUESTED_JOB_NUMBER;
	end
end

fcsh_edge #(
	.W (13)
) u_edge (
	.clk   (MCLK),
	.rst_n (RST_N),
	.tick  (tick),
	.din   (bundle),
	.stb   (stb),
	.smp   (smp),
	.rise  (rise),
	.fall  (fall)
);

////////////////////////////////////////////////////////////////////////////
// state

reg  [1:0] state;
reg        job_loaded;
reg  [7:0] job_id;
reg        run_ack;
reg        load_ack;
reg        load_ok;
reg        cap_ack;
reg        ready;
reg        c_done;
reg        c_fail;

wire online     = is_online(state);
wire std_on     = !COMPAT_MODE && rise[I_RUN];
wire cmp_on     = COMPAT_MODE && stb && smp[I_RUN] && job_loaded;
wire go_off     = stb && !smp[I_RUN];
wire stop_done  = (state == S_STOP) && !INSPECT_BUSY;
wire load_fin   = (state == S_LOAD) && LOAD_DONE;
wire next_ready = is_running(state) && !INSPECT_BUSY && !CAPTURE_START;
wire cap_go     = rise[I_TRIG] && ready && TRIG_SRC_FIELDBUS;

always @(posedge MCLK or negedge RST_N) begin
	if (!RST_N) begin
		state         <= S_OFF;
		job_loaded    <= 1'b0;
		job_id        <= `FCSH_RST_BYTE;
		LOAD_START    <= 1'b0;
		LOAD_NUMBER   <= `FCSH_RST_BYTE;
		LOAD_STARTUP  <= 1'b0;
		load_ok       <= 1'b0;
		c_done        <= 1'b0;
		c_fail        <= 1'b0;
	end else begin
		LOAD_START <= 1'b0;
		case (state)
		S_OFF: begin
			if (rise[I_LOAD]) begin
				LOAD_START   <= 1'b1;
				LOAD_NUMBER  <= smp[12:I_NUM];
				LOAD_STARTUP <= smp[I_BOOT];
				c_done       <= 1'b0;
				c_fail       <= 1'b0;
				state        <= S_LOAD;
			end else if ((std_on || cmp_on) && job_loaded) begin
				state <= S_ON;
			end
		end
		S_ON: begin
			if (go_off) begin
				state <= S_STOP;
			end
		end
		S_STOP: begin
			if (!INSPECT_BUSY) begin
				state <= S_OFF;
			end
		end
		S_LOAD: begin
			if (LOAD_DONE) begin
				load_ok <= LOAD_OK;
				c_done  <= LOAD_OK;
				c_fail  <= !LOAD_OK;
				if (LOAD_OK) begin
					job_id     <= LOAD_NUMBER;
					job_loaded <= 1'b1;
				end
				state <= S_OFF;
			end
		end
		default: begin
			state <= S_OFF;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////
// acknowledges, set wins over clear

always @(posedge MCLK or negedge RST_N) begin
	if (!RST_N) begin
		run_ack  <= 1'b0;
		load_ack <= 1'b0;
		cap_ack  <= 1'b0;
		ready    <= 1'b0;
	end else begin
		if (std_on) begin
			run_ack <= 1'b1;
		end else if (stop_done || (fall[I_RUN] && state == S_OFF)) begin
			run_ack <= 1'b0;
		end
		if (load_fin) begin
			load_ack <= 1'b1;
		end else if (fall[I_LOAD]) begin
			load_ack <= 1'b0;
		end
		if (rise[I_TRIG]) begin
			cap_ack <= 1'b1;
		end else if (fall[I_TRIG]) begin
			cap_ack <= 1'b0;
		end
		ready <= next_ready;
	end
end

////////////////////////////////////////////////////////////////////////////
// engine, illumination and status outputs

always @(posedge MCLK or negedge RST_N) begin
	if (!RST_N) begin
		RUN_ENABLE    <= 1'b0;
		CAPTURE_START <= 1'b0;
		LIGHTS_OFF    <= 1'b0;
	end else begin
		RUN_ENABLE    <= is_running(state);
		CAPTURE_START <= cap_go;
		LIGHTS_OFF    <= COMPAT_MODE && smp[I_LIGHT];
	end
end

reg [7:0]  next_flags;
reg [15:0] next_cstate;

always @* begin
	next_flags = `FCSH_RST_BYTE;
	next_flags[`FCSH_ST_ONLINE]   = online;
	next_flags[`FCSH_ST_RUN_ACK]  = run_ack;
	next_flags[`FCSH_ST_LOAD_ACK] = load_ack;
	next_flags[`FCSH_ST_LOAD_OK]  = load_ok;
	next_flags[`FCSH_ST_READY]    = ready;
	next_flags[`FCSH_ST_CAP_ACK]  = cap_ack;
	next_cstate = `FCSH_RST_WORD;
	next_cstate[`FCSH_CS_ONLINE]    = online;
	next_cstate[`FCSH_CS_FAULT]     = 1'b0;
	next_cstate[`FCSH_CS_LOAD_DONE] = c_done;
	next_cstate[`FCSH_CS_LOAD_FAIL] = c_fail;
end

always @(posedge MCLK or negedge RST_N) begin
	if (!RST_N) begin
		SENSOR_STATE_FLAGS  <= `FCSH_RST_BYTE;
		CURRENT_JOB_NUMBER  <= `FCSH_RST_BYTE;
		COMPAT_DEVICE_STATE <= `FCSH_RST_WORD;
	end else begin
		SENSOR_STATE_FLAGS  <= next_flags;
		CURRENT_JOB_NUMBER  <= job_id;
		COMPAT_DEVICE_STATE <= next_cstate;
	end
end

endmodule

//--- bench/fcsh_handshake_properties.sv
// port assertions for the handshake block
// assumes bind onto fcsh_handshake, a single MCLK domain
`timescale 1ns/1ps
module fcsh_handshake_properties (
	// clock and reset
	input wire        MCLK,
	input wire        RST_N,
	// inputs watched
	input wire        COMPAT_MODE,
	input wire        TRIG_SRC_FIELDBUS,
	input wire        LOAD_DONE,
	input wire        LOAD_OK,
	// outputs watched
	input wire [7:0]  SENSOR_STATE_FLAGS,
	input wire [7:0]  CURRENT_JOB_NUMBER,
	input wire [15:0] COMPAT_DEVICE_STATE,
	input wire        LOAD_START,
	input wire [7:0]  LOAD_NUMBER,
	input wire        RUN_ENABLE,
	input wire        CAPTURE_START
);
default clocking cb @(posedge MCLK);
endclocking
default disable iff (!RST_N);
////////////////////////////////////////////////////////////////////////////
property p_reserved_zero;
	SENSOR_STATE_FLAGS[7] == 1'b0 && SENSOR_STATE_FLAGS[2] == 1'b0;
endproperty
a_reserved_zero: assert property (p_reserved_zero)
	else $error("reserved status bit set");
property p_fault_zero;
	COMPAT_DEVICE_STATE[4] == 1'b0;
endproperty
a_fault_zero: assert property (p_fault_zero)
	else $error("general fault bit set");
property p_run_online;
	!COMPAT_MODE && RUN_ENABLE |-> SENSOR_STATE_FLAGS[0];
endproperty
a_run_online: assert property (p_run_online)
	else $error("job runs while online bit low");
property p_offline_pair;
	!COMPAT_MODE && $fell(SENSOR_STATE_FLAGS[0])
		|-> !SENSOR_STATE_FLAGS[1] && $past(SENSOR_STATE_FLAGS[1]);
endproperty
a_offline_pair: assert property (p_offline_pair)
	else $error("online and run ack not cleared together");
property p_capture_gate;
	!COMPAT_MODE && CAPTURE_START
		|-> SENSOR_STATE_FLAGS[5] && TRIG_SRC_FIELDBUS ##1 !CAPTURE_START;
endproperty
a_capture_gate: assert property (p_capture_gate)
	else $error("capture started while not allowed");
property p_capture_ack;
	!COMPAT_MODE && CAPTURE_START |-> ##[0:2] SENSOR_STATE_FLAGS[6];
endproperty
a_capture_ack: assert property (p_capture_ack)
	else $error("capture ack missing");
property p_load_ok;
	!COMPAT_MODE && LOAD_DONE && LOAD_OK |-> ##[1:3]
		SENSOR_STATE_FLAGS[4:3] == 2'b11 && CURRENT_JOB_NUMBER == LOAD_NUMBER;
endproperty
a_load_ok: assert property (p_load_ok)
	else $error("good load not reported");
property p_load_fail;
	!COMPAT_MODE && LOAD_DONE && !LOAD_OK
		|-> ##[1:3] SENSOR_STATE_FLAGS[4:3] == 2'b01;
endproperty
a_load_fail: assert property (p_load_fail)
	else $error("failed load not reported");
property p_load_offline;
	LOAD_START |-> !RUN_ENABLE ##1 !LOAD_START;
endproperty
a_load_offline: assert property (p_load_offline)
	else $error("load started while running");
endmodule
bind fcsh_handshake fcsh_handshake_properties u_fcsh_handshake_properties (
	.MCLK(MCLK), .RST_N(RST_N), .COMPAT_MODE(COMPAT_MODE),
	.TRIG_SRC_FIELDBUS(TRIG_SRC_FIELDBUS), .LOAD_DONE(LOAD_DONE),
	.LOAD_OK(LOAD_OK), .SENSOR_STATE_FLAGS(SENSOR_STATE_FLAGS),
	.CURRENT_JOB_NUMBER(CURRENT_JOB_NUMBER),
	.COMPAT_DEVICE_STATE(COMPAT_DEVICE_STATE), .LOAD_START(LOAD_START),
	.LOAD_NUMBER(LOAD_NUMBER), .RUN_ENABLE(RUN_ENABLE),
	.CAPTURE_START(CAPTURE_START));

//--- bench/fcsh_engine_model.sv
// loader and inspection engine model behind the handshake block
// assumes the block clock; number FF always fails to load
`timescale 1ns/1ps
module fcsh_engine_model (
	// clock and reset
	input wire       clk,
	input wire       rst_n,
	// requests
	input wire       load_start,
	input wire [7:0] load_number,
	input wire       capture_start,
	// answers
	output reg       load_done,
	output reg       load_ok,
	output reg       inspect_busy
);
reg [2:0] load_cnt;
reg [4:0] busy_cnt;
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		load_cnt <= 3'h0;
		busy_cnt <= 5'h00;
		load_done <= 1'b0;
		load_ok <= 1'b0;
		inspect_busy <= 1'b0;
	end else begin
		load_done <= load_cnt == 3'h1;
		load_ok <= load_cnt == 3'h1 && load_number != 8'hFF;
		load_cnt <= load_start ? 3'h4 : load_cnt - {2'h0, load_cnt != 3'h0};
		inspect_busy <= capture_start || busy_cnt > 5'h01;
		busy_cnt <= capture_start ? 5'h14 : busy_cnt - {4'h0, busy_cnt != 5'h00};
	end
end
endmodule

//--- bench/test_fcsh_handshake.sv
// self-checking bench for the handshake block
// assumes a short exchange cycle of 16 clocks
`timescale 1ns/1ps
module test_fcsh_handshake;
reg         MCLK = 1'b0;
reg         RST_N = 1'b0;
reg         cm = 1'b0;
reg         src = 1'b1;
reg  [7:0]  rq = 8'h00;
reg  [7:0]  jn = 8'h00;
reg  [7:0]  cc = 8'h00;
reg  [15:0] dc = 16'h0000;
wire [7:0]  st, cj, ln;
wire [15:0] ds;
wire        ls, lst, ld, lk, re, cs, ib, lt;
integer     bad_count = 0;
integer     check_count = 0;
integer     caps = 0;
always #2 MCLK = ~MCLK;
always @(posedge MCLK) if (cs === 1'b1) caps = caps + 1;
fcsh_handshake #(.CYCLE_CLKS(21'h000010)) u_fcsh_handshake (
	.MCLK(MCLK), .RST_N(RST_N), .HOST_REQUEST_FLAGS(rq),
	.REQUESTED_JOB_NUMBER(jn), .COMPAT_MODE(cm), .COMPAT_DEVICE_CONTROL(dc),
	.COMPAT_CAPTURE_CONTROL(cc), .SENSOR_STATE_FLAGS(st),
	.CURRENT_JOB_NUMBER(cj), .COMPAT_DEVICE_STATE(ds), .LOAD_START(ls),
	.LOAD_NUMBER(ln), .LOAD_STARTUP(lst), .LOAD_DONE(ld), .LOAD_OK(lk),
	.RUN_ENABLE(re), .CAPTURE_START(cs), .INSPECT_BUSY(ib),
	.TRIG_SRC_FIELDBUS(src), .LIGHTS_OFF(lt));
fcsh_engine_model u_fcsh_engine_model (
	.clk(MCLK), .rst_n(RST_N), .load_start(ls), .load_number(ln),
	.capture_start(cs), .load_done(ld), .load_ok(lk), .inspect_busy(ib));
////////////////////////////////////////////////////////////////////////////
task chk(input [15:0] seen, input [15:0] exp);
	begin
		check_count = check_count + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
endtask
task put(input [7:0] f, input [7:0] n);
	begin
		@(posedge MCLK);
		#1 rq = f;
		jn = n;
		repeat (64) @(posedge MCLK);
		#1;
	end
endtask
task cput(input [15:0] v);
	begin
		@(posedge MCLK);
		#1 dc = v;
		repeat (64) @(posedge MCLK);
		#1;
	end
endtask
task stop_test;
	begin
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
endtask
initial begin
	#40000 bad_count = bad_count + 1;
	stop_test;
end
initial begin
	repeat (5) @(posedge MCLK);
	#1 RST_N = 1'b1;
	chk(st, 16'h0000);
	chk(cj, 16'h0000);
	put(8'h01, 8'h00);
	chk(st[1:0], 2'b10);
	put(8'h00, 8'h00);
	chk(st[1], 1'b0);
	$display("reset and refused online done");
	put(8'h04, 8'h5A);
	put(8'h06, 8'h5A);
	chk({ln, 7'h00, lst}, 16'h5A01);
	chk(st[4:3], 2'b11);
	chk(cj, 16'h005A);
	put(8'h00, 8'h5A);
	chk(st[3], 1'b0);
	put(8'h02, 8'hFF);
	chk(st[4:3], 2'b01);
	chk(cj, 16'h005A);
	chk(lst, 1'b0);
	$display("program load done");
	put(8'h00, 8'hFF);
	put(8'h01, 8'hFF);
	chk({st[1:0], re}, 3'b111);
	chk(st[5], 1'b1);
	put(8'h03, 8'h11);
	chk({st[3], cj}, 16'h005A);
	put(8'h09, 8'h00);
	chk(caps, 1);
	chk(st[6], 1'b1);
	put(8'h01, 8'h00);
	chk(st[6], 1'b0);
	src = 1'b0;
	put(8'h09, 8'h00);
	chk(caps, 1);
	chk(st[6], 1'b1);
	put(8'h01, 8'h00);
	src = 1'b1;
	put(8'h00, 8'h00);
	chk({st[1:0], re}, 3'b000);
	chk(cj, 16'h005A);
	$display("online and capture done");
	cm = 1'b1;
	cput(16'h0001);
	cput(16'h2103);
	chk(ds[6:5], 2'b01);
	cput(16'h0001);
	cput(16'hFF03);
	chk(ds[6:5], 2'b10);
	cput(16'h0008);
	chk({ds[4], ds[0], lt}, 3'b011);
	cput(16'h0001);
	chk(ds[0], 1'b0);
	$display("compatibility mode done");
	stop_test;
end
endmodule
